// [pcmux_top.v]
// Function
// - bit 4 pin: ch3 transfer end in setting 1, input or area 6 select in 2, unused in 3.
// - bit 3 pin is a general input when its direction bit is 0, area 5 select when 1.
// - in ch2 setting 1 the bit 3 pin level also drives the active-low ch2 request.
// - bit 2 pin is ch2 transfer end in setting 1, else input or area 4 select by direction.
// - the direction register is write-only and reads back as all ones.
// - a port read gives the data bit where direction is 1 and the pin level where 0.
// - direction clears on reset and hardware standby and holds in software standby.
`timescale 1ns/100ps
`include "pcmux_defs.vh"

module pcmux_top (
  mclk,
  srst,
  hw_standby,
  sw_standby,
  dir_wr_en,
  dir_wr_data,
  dir_rd_data,
  data_wr_en,
  data_wr_data,
  port_rd_data,
  port_c_pin_in,
  ch3_src_a,
  ch3_src_b,
  ch2_src_a,
  ch2_src_b,
  dma_ch3_end_in_n,
  dma_ch2_end_in_n,
  area6_sel_in_n,
  area5_sel_in_n,
  area4_sel_in_n,
  dma_ch2_request_n,
  port_c_bit4_pin_out,
  port_c_bit4_pin_oe,
  port_c_bit3_pin_out,
  port_c_bit3_pin_oe,
  port_c_bit2_pin_out,
  port_c_bit2_pin_oe
);

  input wire mclk;
  input wire srst;
  input wire hw_standby;
  input wire sw_standby;
  input wire dir_wr_en;
  input wire [`PCMUX_PORT_W-1:0] dir_wr_data;
  output wire [`PCMUX_PORT_W-1:0] dir_rd_data;
  input wire data_wr_en;
  input wire [`PCMUX_PORT_W-1:0] data_wr_data;
  output wire [`PCMUX_PORT_W-1:0] port_rd_data;
  input wire [`PCMUX_PORT_W-1:0] port_c_pin_in;
  input wire [`PCMUX_SRC_A_W-1:0] ch3_src_a;
  input wire [`PCMUX_SRC_B_W-1:0] ch3_src_b;
  input wire [`PCMUX_SRC_A_W-1:0] ch2_src_a;
  input wire [`PCMUX_SRC_B_W-1:0] ch2_src_b;
  input wire dma_ch3_end_in_n;
  input wire dma_ch2_end_in_n;
  input wire area6_sel_in_n;
  input wire area5_sel_in_n;
  input wire area4_sel_in_n;
  output wire dma_ch2_request_n;
  output wire port_c_bit4_pin_out;
  output wire port_c_bit4_pin_oe;
  output wire port_c_bit3_pin_out;
  output wire port_c_bit3_pin_oe;
  output wire port_c_bit2_pin_out;
  output wire port_c_bit2_pin_oe;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [`PCMUX_PORT_W-1:0] port_c_direction_reg;
  reg [`PCMUX_PORT_W-1:0] port_c_data_reg;
  reg [`PCMUX_PORT_W-1:0] pin_meta_reg;
  reg [`PCMUX_PORT_W-1:0] pin_sync_reg;
  reg [`PCMUX_SET_W-1:0] ch3_set_reg;
  reg [`PCMUX_SET_W-1:0] ch2_set_reg;
  reg [`PCMUX_PORT_W-1:0] dir_rd_reg;
  reg [`PCMUX_PORT_W-1:0] port_rd_reg;
  reg request_n_reg;
  reg bit4_out_reg;
  reg bit4_oe_reg;
  reg bit3_out_reg;
  reg bit3_oe_reg;
  reg bit2_out_reg;
  reg bit2_oe_reg;

  reg [`PCMUX_SET_W-1:0] ch3_set_next;
  reg [`PCMUX_SET_W-1:0] ch2_set_next;
  reg [`PCMUX_PORT_W-1:0] port_rd_next;
  reg request_n_next;
  reg bit4_out_next;
  reg bit4_oe_next;
  reg bit3_out_next;
  reg bit3_oe_next;
  reg bit2_out_next;
  reg bit2_oe_next;

  wire [`PCMUX_SET_W-1:0] ch3_set_comb;
  wire [`PCMUX_SET_W-1:0] ch2_set_comb;
  wire bit4_direction = port_c_direction_reg[`PCMUX_BIT4];
  wire bit3_direction = port_c_direction_reg[`PCMUX_BIT3];
  wire bit2_direction = port_c_direction_reg[`PCMUX_BIT2];

  // ----------------------------------------------------------------
  // setting decoders
  // ----------------------------------------------------------------
  // channel 3 decoder, with the unusable setting
  pcmux_dma_decode #(
    .HAS_SET3(1)
  ) u_ch3_decode (
    .src_a(ch3_src_a),
    .src_b(ch3_src_b),
    .setting(ch3_set_comb)
  );

  // channel 2 decoder
  pcmux_dma_decode #(
    .HAS_SET3(0)
  ) u_ch2_decode (
    .src_a(ch2_src_a),
    .src_b(ch2_src_b),
    .setting(ch2_set_comb)
  );

  // ----------------------------------------------------------------
  // port registers
  // ----------------------------------------------------------------
  // direction and data: cleared by reset and hardware standby only
  always @(posedge mclk) begin
    if (srst || hw_standby) begin
      port_c_direction_reg <= `PCMUX_DIR_RST;
      port_c_data_reg <= `PCMUX_DATA_RST;
    end else begin
      if (dir_wr_en) begin
        port_c_direction_reg <= dir_wr_data;
      end
      if (data_wr_en) begin
        port_c_data_reg <= data_wr_data;
      end
    end
  end

  // two-stage pin synchroniser
  always @(posedge mclk) begin
    if (srst) begin
      pin_meta_reg <= `PCMUX_DATA_RST;
      pin_sync_reg <= `PCMUX_DATA_RST;
    end else begin
      pin_meta_reg <= port_c_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // pin function selection
  // ----------------------------------------------------------------
  // settings latch the decode so the change lands one cycle later
  always @* begin
    ch3_set_next = ch3_set_comb;
    ch2_set_next = ch2_set_comb;
  end

  // bit 4 function from channel 3 setting
  always @* begin
    bit4_out_next = `PCMUX_PIN_IDLE;
    bit4_oe_next = `PCMUX_OE_OFF;
    case (ch3_set_reg)
      `PCMUX_SET1: begin
        bit4_out_next = dma_ch3_end_in_n;
        bit4_oe_next = `PCMUX_OE_ON;
      end
      `PCMUX_SET3: begin
        bit4_oe_next = `PCMUX_OE_OFF;
      end
      default: begin
        bit4_out_next = area6_sel_in_n;
        bit4_oe_next = bit4_direction;
      end
    endcase
  end

  // bit 3 function and the channel 2 request tap
  always @* begin
    bit3_out_next = area5_sel_in_n;
    bit3_oe_next = bit3_direction;
    request_n_next = `PCMUX_PIN_IDLE;
    if (ch2_set_reg == `PCMUX_SET1) begin
      request_n_next = pin_sync_reg[`PCMUX_BIT3];
    end
  end

  // bit 2 function from channel 2 setting
  always @* begin
    if (ch2_set_reg == `PCMUX_SET1) begin
      bit2_out_next = dma_ch2_end_in_n;
      bit2_oe_next = `PCMUX_OE_ON;
    end else begin
      bit2_out_next = area4_sel_in_n;
      bit2_oe_next = bit2_direction;
    end
  end

  // port read: stored bit where driven, pin level otherwise
  always @* begin
    port_rd_next = (port_c_direction_reg & port_c_data_reg) |
                   (~port_c_direction_reg & pin_sync_reg);
  end

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  // every output leaves from a flop
  always @(posedge mclk) begin
    if (srst) begin
      ch3_set_reg <= `PCMUX_SET2;
      ch2_set_reg <= `PCMUX_SET2;
      dir_rd_reg <= `PCMUX_DIR_READ;
      port_rd_reg <= `PCMUX_DATA_RST;
      request_n_reg <= `PCMUX_PIN_IDLE;
      bit4_out_reg <= `PCMUX_PIN_IDLE;
      bit4_oe_reg <= `PCMUX_OE_OFF;
      bit3_out_reg <= `PCMUX_PIN_IDLE;
      bit3_oe_reg <= `PCMUX_OE_OFF;
      bit2_out_reg <= `PCMUX_PIN_IDLE;
      bit2_oe_reg <= `PCMUX_OE_OFF;
    end else begin
      ch3_set_reg <= ch3_set_next;
      ch2_set_reg <= ch2_set_next;
      dir_rd_reg <= `PCMUX_DIR_READ;
      port_rd_reg <= port_rd_next;
      request_n_reg <= request_n_next;
      bit4_out_reg <= bit4_out_next;
      bit4_oe_reg <= bit4_oe_next;
      bit3_out_reg <= bit3_out_next;
      bit3_oe_reg <= bit3_oe_next;
      bit2_out_reg <= bit2_out_next;
      bit2_oe_reg <= bit2_oe_next;
    end
  end

  assign dir_rd_data = dir_rd_reg;
  assign port_rd_data = port_rd_reg;
  assign dma_ch2_request_n = request_n_reg;
  assign port_c_bit4_pin_out = bit4_out_reg;
  assign port_c_bit4_pin_oe = bit4_oe_reg;
  assign port_c_bit3_pin_out = bit3_out_reg;
  assign port_c_bit3_pin_oe = bit3_oe_reg;
  assign port_c_bit2_pin_out = bit2_out_reg;
  assign port_c_bit2_pin_oe = bit2_oe_reg;

endmodule

// [pcmux_defs.vh]
`ifndef PCMUX_DEFS_VH
`define PCMUX_DEFS_VH

// ----------------------------------------------------------------
// dma setting groups
// ----------------------------------------------------------------
`define PCMUX_SET_W 2
`define PCMUX_SET1 2'h1
`define PCMUX_SET2 2'h2
`define PCMUX_SET3 2'h3

// ----------------------------------------------------------------
// port c layout and reset values
// ----------------------------------------------------------------
`define PCMUX_PORT_W 8
`define PCMUX_BIT2 2
`define PCMUX_BIT3 3
`define PCMUX_BIT4 4
`define PCMUX_DIR_RST 8'h00
`define PCMUX_DATA_RST 8'h00
`define PCMUX_DIR_READ 8'hff

// ----------------------------------------------------------------
// source select field positions
// ----------------------------------------------------------------
`define PCMUX_SRC_A_W 3
`define PCMUX_SRC_B_W 2
`define PCMUX_SRC_A2 2
`define PCMUX_SRC_A1 1
`define PCMUX_SRC_A0 0
`define PCMUX_SRC_B2 1
`define PCMUX_SRC_B1 0

// ----------------------------------------------------------------
// pin drive levels
// ----------------------------------------------------------------
`define PCMUX_PIN_IDLE 1'h1
`define PCMUX_OE_OFF 1'h0
`define PCMUX_OE_ON 1'h1

`endif

// [pcmux_dma_decode.v]
`timescale 1ns/100ps
`include "pcmux_defs.vh"

// ----------------------------------------------------------------
// combinational decode of one dma channel's source fields into a
// setting group; only channel 3 has the unusable setting 3
// ----------------------------------------------------------------
module pcmux_dma_decode #(
  parameter HAS_SET3 = 0
) (
  input wire [`PCMUX_SRC_A_W-1:0] src_a,
  input wire [`PCMUX_SRC_B_W-1:0] src_b,
  output reg [`PCMUX_SET_W-1:0] setting
);

  wire a_both = src_a[`PCMUX_SRC_A2] & src_a[`PCMUX_SRC_A1];
  wire a0 = src_a[`PCMUX_SRC_A0];
  wire b2 = src_b[`PCMUX_SRC_B2];
  wire b1 = src_b[`PCMUX_SRC_B1];

  // setting group from the field pattern
  always @* begin
    setting = `PCMUX_SET2;
    if (b2 && b1) begin
      setting = `PCMUX_SET1;
    end else if (a_both && !a0 && b2) begin
      if (HAS_SET3 != 0) begin
        setting = `PCMUX_SET3;
      end else begin
        setting = `PCMUX_SET1;
      end
    end
  end

endmodule

// [pcmux_partner.sv]
`timescale 1ns/100ps

// --------------------
// far side model
// --------------------
module pcmux_partner (
  input wire mclk,
  input wire [7:0] ext_level,
  input wire [2:0] drv_out,
  input wire [2:0] drv_oe,
  output logic [7:0] pin_level,
  output logic [4:0] strobes_n
);
  // dma ends and selects count up together by 11 each cycle so stale outputs show up
  initial strobes_n = 5'h1f;
  always @(posedge mclk) begin
    strobes_n <= strobes_n + 5'h0b;
  end
  // a driven pin shows the block's level, otherwise the board's
  always @* begin
    pin_level = ext_level;
    pin_level[4:2] = (drv_oe & drv_out) | (~drv_oe & ext_level[4:2]);
  end
endmodule

// [pcmux_assertions.sv]
`timescale 1ns/100ps

// --------------------
// pin mux checker
// --------------------
module pcmux_checker (
  input wire mclk,
  input wire srst,
  input wire hw_standby,
  input wire dir_wr_en,
  input wire [7:0] dir_wr_data,
  input wire [7:0] port_c_pin_in,
  input wire [2:0] ch3_src_a,
  input wire [1:0] ch3_src_b,
  input wire [2:0] ch2_src_a,
  input wire [1:0] ch2_src_b,
  input wire dma_ch3_end_in_n,
  input wire dma_ch2_end_in_n,
  input wire area4_sel_in_n,
  input wire dma_ch2_request_n,
  input wire port_c_bit4_pin_out,
  input wire port_c_bit4_pin_oe,
  input wire port_c_bit3_pin_oe,
  input wire port_c_bit2_pin_out,
  input wire port_c_bit2_pin_oe
);
  // decoded settings
  wire c3s1 = &ch3_src_b;
  wire c3s3 = ch3_src_a == 3'h6 && ch3_src_b == 2'h2;
  wire c2s1 = &ch2_src_b || (ch2_src_a == 3'h6 && ch2_src_b[1]);
  reg [1:0] run_reg;
  // cycles since the last clear, saturating at three
  always @(posedge mclk) begin
    run_reg <= (srst || hw_standby) ? 2'h0 : run_reg + {1'h0, run_reg != 2'h3};
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_bit3_dir: assert property ($past(dir_wr_en) && run_reg != 2'h0 && !hw_standby
    |=> port_c_bit3_pin_oe == $past(dir_wr_data[3], 2)) else $error("bit3 enable wrong");
  chk_ch3_end: assert property (run_reg[1] && $past(c3s1, 2)
    |-> port_c_bit4_pin_oe && port_c_bit4_pin_out == $past(dma_ch3_end_in_n))
    else $error("bit4 end wrong");
  chk_ch3_unused: assert property (run_reg[1] && $past(c3s3, 2) |-> !port_c_bit4_pin_oe)
    else $error("bit4 driven when unusable");
  chk_ch2_end: assert property (run_reg[1] && $past(c2s1, 2)
    |-> port_c_bit2_pin_oe && port_c_bit2_pin_out == $past(dma_ch2_end_in_n))
    else $error("bit2 end wrong");
  chk_ch2_select: assert property (run_reg[1] && !$past(c2s1, 2)
    |-> port_c_bit2_pin_out == $past(area4_sel_in_n)) else $error("bit2 select wrong");
  chk_req_idle: assert property (run_reg[1] && !$past(c2s1, 2) |-> dma_ch2_request_n)
    else $error("request while not routed");
  chk_req_follows: assert property (run_reg == 2'h3 && $past(c2s1, 2)
    |-> dma_ch2_request_n == $past(port_c_pin_in[3], 3)) else $error("request wrong");
  chk_standby_clear: assert property (hw_standby |-> ##2 !port_c_bit3_pin_oe)
    else $error("standby kept direction");
endmodule

bind pcmux_top pcmux_checker pcmux_checker_inst (.mclk(mclk), .srst(srst),
  .hw_standby(hw_standby), .dir_wr_en(dir_wr_en), .dir_wr_data(dir_wr_data),
  .port_c_pin_in(port_c_pin_in), .ch3_src_a(ch3_src_a), .ch3_src_b(ch3_src_b),
  .ch2_src_a(ch2_src_a), .ch2_src_b(ch2_src_b), .dma_ch3_end_in_n(dma_ch3_end_in_n),
  .dma_ch2_end_in_n(dma_ch2_end_in_n), .area4_sel_in_n(area4_sel_in_n),
  .dma_ch2_request_n(dma_ch2_request_n), .port_c_bit4_pin_out(port_c_bit4_pin_out),
  .port_c_bit4_pin_oe(port_c_bit4_pin_oe), .port_c_bit3_pin_oe(port_c_bit3_pin_oe),
  .port_c_bit2_pin_out(port_c_bit2_pin_out), .port_c_bit2_pin_oe(port_c_bit2_pin_oe));

// [tb.sv]
`timescale 1ns/100ps

// --------------------
// pin mux testbench
// --------------------
module tb;
  reg mclk = 1'h0, srst = 1'h1, hw_standby = 1'h0, sw_standby = 1'h0;
  reg dir_wr_en = 1'h0, data_wr_en = 1'h0;
  reg [7:0] dir_wr_data = 8'h00, data_wr_data = 8'h00, ext_level = 8'h00, dir_m, data_m;
  reg [2:0] ch3_src_a = 3'h0, ch2_src_a = 3'h0;
  reg [1:0] ch3_src_b = 2'h0, ch2_src_b = 2'h0;
  reg [4:0] ps;
  wire [7:0] dir_rd_data, port_rd_data, pin_level;
  wire [4:0] sn;
  wire req_n, o4, e4, o3, e3, o2, e2;
  int bad_count = 0, tests_run = 0;

  pcmux_top pcmux_top_inst (.mclk(mclk), .srst(srst), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .dir_wr_en(dir_wr_en), .dir_wr_data(dir_wr_data),
    .dir_rd_data(dir_rd_data), .data_wr_en(data_wr_en), .data_wr_data(data_wr_data),
    .port_rd_data(port_rd_data), .port_c_pin_in(pin_level), .ch3_src_a(ch3_src_a),
    .ch3_src_b(ch3_src_b), .ch2_src_a(ch2_src_a), .ch2_src_b(ch2_src_b),
    .dma_ch3_end_in_n(sn[4]), .dma_ch2_end_in_n(sn[3]), .area6_sel_in_n(sn[2]),
    .area5_sel_in_n(sn[1]), .area4_sel_in_n(sn[0]), .dma_ch2_request_n(req_n),
    .port_c_bit4_pin_out(o4), .port_c_bit4_pin_oe(e4), .port_c_bit3_pin_out(o3),
    .port_c_bit3_pin_oe(e3), .port_c_bit2_pin_out(o2), .port_c_bit2_pin_oe(e2));
  pcmux_partner pcmux_partner_inst (.mclk(mclk), .ext_level(ext_level),
    .drv_out({o4, o3, o2}), .drv_oe({e4, e3, e2}), .pin_level(pin_level), .strobes_n(sn));

  // clock and the strobe values the design saw at the last edge
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) ps <= sn;

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic compare(input [7:0] got, input [7:0] exp, input [7:0] mask);
    tests_run++;
    if (((got ^ exp) & mask) !== 8'h00) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // reference model of the mux, compared against every output
  task automatic check_all();
    bit s31, s33, s21;
    reg [7:0] drv;
    s31 = &ch3_src_b;
    s33 = ch3_src_a == 3'h6 && ch3_src_b == 2'h2;
    s21 = &ch2_src_b || (ch2_src_a == 3'h6 && ch2_src_b[1]);
    drv = {3'h0, s31, 1'h0, s21, 2'h0};
    compare({e4, o4, e3, o3, e2, o2, req_n, 1'h0}, {s31 | (!s33 & dir_m[4]),
      s31 ? ps[4] : (s33 | ps[2]), dir_m[3], ps[1], s21 | dir_m[2], s21 ? ps[3] : ps[0],
      s21 ? ext_level[3] : 1'h1, 1'h0}, {6'h3f, !(s21 & dir_m[3]), 1'h0});
    compare(port_rd_data, (dir_m & data_m) | (~dir_m & ext_level), ~(~dir_m & drv));
    compare(dir_rd_data, 8'hff, 8'hff);
  endtask

  // random writes, settings and pin levels, with standby and a mid-run reset
  initial begin
    reg [31:0] r;
    void'($urandom(14));
    step(10);
    srst = 1'h0;
    dir_m = 8'h00;
    data_m = 8'h00;
    step(4);
    check_all();
    for (int i = 0; i < 200; i++) begin
      r = $urandom;
      {hw_standby, sw_standby, data_wr_en, dir_wr_en} = {r[29:27] == 3'h0, r[26:24]};
      {ext_level, data_wr_data, dir_wr_data} = r[23:0];
      r = $urandom;
      {ch3_src_a, ch3_src_b, ch2_src_a, ch2_src_b} = r[9:0];
      srst = i == 100;
      step(1);
      if (srst || hw_standby) begin
        dir_m = 8'h00;
        data_m = 8'h00;
      end else begin
        if (dir_wr_en) dir_m = dir_wr_data;
        if (data_wr_en) data_m = data_wr_data;
      end
      {srst, hw_standby, data_wr_en, dir_wr_en} = 4'h0;
      step(4);
      check_all();
    end
    report_and_stop();
  end

  // about 1000 cycles are needed; cut off well beyond that
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
endmodule
